// file: cmh_defs.svh
// Constants for the mailbox header word block
// Assumes inclusion by bare name from the header block and the bench
`ifndef CMH_DEFS_SVH
`define CMH_DEFS_SVH
`define CMH_HDR_OFFSET   12'h080
`define CMH_BIT_FDF      31
`define CMH_BIT_BRS      30
`define CMH_BIT_ESI      29
`define CMH_BIT_RSV_HI   28
`define CMH_CODE_HI      27
`define CMH_CODE_LO      24
`define CMH_BIT_RSV_LO   23
`define CMH_BIT_SRR      22
`define CMH_BIT_IDE      21
`define CMH_BIT_RTR      20
`define CMH_DLC_HI       19
`define CMH_DLC_LO       16
`define CMH_TS_HI        15
`define CMH_HDR_RESET    32'h0000_0000
`define CMH_WRITE_MASK   32'hEF7F_0000
`define CMH_CODE_RX_EMPTY   4'h4
`define CMH_CODE_RX_FULL    4'h2
`define CMH_CODE_RX_OVERRUN 4'h6
`define CMH_CODE_TX_DATA    4'hC
`define CMH_CODE_TX_INACT   4'h8
`define CMH_FIFO_WIDTH   32
`define CMH_FIFO_DEPTH   8
`endif

// file: cmh_pkg.sv
// Types for the mailbox header word block
// Assumes nothing beyond a SystemVerilog compiler
package cmh_pkg;
  typedef enum logic [1:0] {
    CMH_TX_OK,
    CMH_TX_ARB_LOSS,
    CMH_TX_BIT_ERR
  } cmh_bit_result_type;
endpackage

// file: cmh_fifo_if.sv
// Valid/ready word channel between the header block and its FIFO
// Assumes one clock shared by both ends
`timescale 1ns/1ps
interface cmh_fifo_if #(parameter int WIDTH = 32);
  logic             valid;
  logic             ready;
  logic [WIDTH-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface

// file: cmh_fifo.sv
// Synchronous FIFO with valid/ready on both sides
// Assumes one clock and asynchronous active-high reset
`timescale 1ns/1ps
module cmh_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 8
) (
  input  wire logic i_core_clk,
  input  wire logic i_rst,
  cmh_fifo_if.snk   wr,
  cmh_fifo_if.src   rd
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0]    wp_q;
  logic [AW-1:0]    rp_q;
  logic [AW:0]      cnt_q;
  logic             push;
  logic             pop;

  assign wr.ready = (cnt_q != (AW+1)'(DEPTH));
  assign rd.valid = (cnt_q != '0);
  assign rd.data  = mem_q[rp_q];
  assign push     = wr.valid && wr.ready;
  assign pop      = rd.valid && rd.ready;

  always_ff @(posedge i_core_clk) begin
    if (push) begin
      mem_q[wp_q] <= wr.data;
    end
  end

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      wp_q  <= '0;
      rp_q  <= '0;
      cnt_q <= '0;
    end else begin
      if (push) begin
        wp_q <= (wp_q == AW'(DEPTH-1)) ? '0 : wp_q + 1'b1;
      end
      if (pop) begin
        rp_q <= (rp_q == AW'(DEPTH-1)) ? '0 : rp_q + 1'b1;
      end
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

  AST_FIFO_NO_OVERFLOW: assert property (@(posedge i_core_clk) disable iff (i_rst)
    cnt_q <= (AW+1)'(DEPTH)) else $error("FIFO count above depth");
endmodule // cmh_fifo

// file: cmh_dlc_map.sv
// Maps a four-bit length code to its payload size in bytes
// Assumes a purely combinational use
`timescale 1ns/1ps
module cmh_dlc_map (
  input  wire logic [3:0] i_dlc,
  output logic      [6:0] o_bytes
);
  always_comb begin
    case (i_dlc)
      4'h9:    o_bytes = 7'h0C;
      4'hA:    o_bytes = 7'h10;
      4'hB:    o_bytes = 7'h14;
      4'hC:    o_bytes = 7'h18;
      4'hD:    o_bytes = 7'h20;
      4'hE:    o_bytes = 7'h30;
      4'hF:    o_bytes = 7'h40;
      default: o_bytes = {3'h0, i_dlc};
    endcase
  end
endmodule // cmh_dlc_map

// file: cmh_header.sv
// Mailbox header word zero: CPU port, engine port, timestamp counter
// Assumes engine strobes are on i_core_clk; CPU reads are drained via FIFO
`timescale 1ns/1ps
`include "cmh_defs.svh"
module cmh_header (
  input  wire logic        i_core_clk,
  input  wire logic        i_rst,
  input  wire logic        i_cpu_sel,
  input  wire logic        i_cpu_wr,
  input  wire logic [11:0] i_cpu_addr,
  input  wire logic [31:0] i_cpu_wdata,
  input  wire logic        i_cpu_rd_ready,
  output logic             o_cpu_rd_valid,
  output logic      [31:0] o_cpu_rdata,
  output logic             o_cpu_ready,
  input  wire logic        i_cpu_serviced,
  input  wire logic        i_rx_store,
  input  wire logic [11:0] i_rx_flags,
  input  wire logic        i_tx_done,
  input  wire logic        i_id_start,
  input  wire logic        i_error_passive,
  input  wire logic        i_chk_srr,
  input  wire logic        i_chk_rtr,
  input  wire logic        i_bus_bit,
  output logic             o_tx_esi_bit,
  output logic             o_tx_esi_present,
  output logic             o_tx_remote,
  output logic      [6:0]  o_tx_payload_bytes,
  output logic             o_rx_match_enable,
  output logic             o_rx_accept_remote,
  output logic             o_arb_loss,
  output logic             o_bit_error,
  output logic      [15:0] o_timestamp
);
  logic [31:0] hdr_q;
  logic [15:0] ts_q;
  logic        unread_q;
  logic        arb_loss_q;
  logic        bit_err_q;
  logic        hit;
  logic        cpu_wr_acc;
  logic        cpu_rd_acc;
  logic [3:0]  code;
  logic [3:0]  code_d;
  logic [6:0]  dlc_bytes;
  cmh_pkg::cmh_bit_result_type chk_res;
  localparam logic [31:0] WR_MASK = `CMH_WRITE_MASK;

  cmh_fifo_if #(.WIDTH(`CMH_FIFO_WIDTH)) rd_in ();
  cmh_fifo_if #(.WIDTH(`CMH_FIFO_WIDTH)) rd_out ();

  assign hit  = i_cpu_sel && (i_cpu_addr == `CMH_HDR_OFFSET);
  assign code = hdr_q[`CMH_CODE_HI:`CMH_CODE_LO];
  // Reads stall when the return FIFO is full
  assign o_cpu_ready = i_cpu_wr || rd_in.ready;
  assign cpu_wr_acc  = hit && i_cpu_wr;
  assign cpu_rd_acc  = hit && !i_cpu_wr && rd_in.ready;

  assign rd_in.valid  = cpu_rd_acc;
  assign rd_in.data   = hdr_q;
  assign rd_out.ready = i_cpu_rd_ready;
  assign o_cpu_rd_valid = rd_out.valid;
  assign o_cpu_rdata    = rd_out.data;

  cmh_fifo #(.WIDTH(`CMH_FIFO_WIDTH), .DEPTH(`CMH_FIFO_DEPTH)) u_rd_fifo (
    .i_core_clk (i_core_clk),
    .i_rst      (i_rst),
    .wr         (rd_in.snk),
    .rd         (rd_out.src)
  );

  // Free-running counter, wraps with no flag
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      ts_q <= 16'h0000;
    end else begin
      ts_q <= ts_q + 16'h0001;
    end
  end
  assign o_timestamp = ts_q;

  // Next code from engine events; engine wins over a same-cycle CPU write
  always_comb begin
    code_d = code;
    if (cpu_wr_acc) begin
      code_d = i_cpu_wdata[`CMH_CODE_HI:`CMH_CODE_LO];
    end
    if (i_rx_store && !code[0]) begin
      case (code)
        `CMH_CODE_RX_EMPTY:   code_d = `CMH_CODE_RX_FULL;
        `CMH_CODE_RX_FULL:    code_d = unread_q ? `CMH_CODE_RX_OVERRUN
                                                : `CMH_CODE_RX_FULL;
        `CMH_CODE_RX_OVERRUN: code_d = unread_q ? `CMH_CODE_RX_OVERRUN
                                                : `CMH_CODE_RX_FULL;
        default:              code_d = code;
      endcase
    end
    if (i_tx_done && code == `CMH_CODE_TX_DATA) begin
      code_d = `CMH_CODE_TX_INACT;
    end
  end

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      hdr_q <= `CMH_HDR_RESET;
    end else begin
      if (cpu_wr_acc) begin
        // Timestamp and reserved bits are masked from CPU writes
        hdr_q[31:16] <= i_cpu_wdata[31:16] & WR_MASK[31:16];
      end
      if (i_rx_store && !code[0]) begin
        hdr_q[`CMH_BIT_FDF:`CMH_BIT_ESI]  <= i_rx_flags[11:9];
        hdr_q[`CMH_BIT_SRR:`CMH_BIT_RTR]  <= i_rx_flags[8:6];
        hdr_q[`CMH_DLC_HI:`CMH_DLC_LO]    <= i_rx_flags[3:0];
      end
      hdr_q[`CMH_CODE_HI:`CMH_CODE_LO] <= code_d;
      if (i_id_start) begin
        hdr_q[`CMH_TS_HI:0] <= ts_q;
      end
    end
  end

  // Tracks whether the CPU has serviced the stored frame
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      unread_q <= 1'b0;
    end else if (i_rx_store && !code[0]) begin
      unread_q <= 1'b1;
    end else if (i_cpu_serviced) begin
      unread_q <= 1'b0;
    end
  end

  // Transmit-side and receive-side views of the word
  assign o_tx_esi_present = hdr_q[`CMH_BIT_FDF];
  assign o_tx_esi_bit     = i_error_passive;
  assign o_tx_remote      = hdr_q[`CMH_BIT_RTR] && !hdr_q[`CMH_BIT_FDF];
  assign o_rx_accept_remote = hdr_q[`CMH_BIT_RTR];
  assign o_rx_match_enable  = !code[0] && !code[3] && (code != 4'h0);

  cmh_dlc_map u_dlc (
    .i_dlc   (hdr_q[`CMH_DLC_HI:`CMH_DLC_LO]),
    .o_bytes (dlc_bytes)
  );
  assign o_tx_payload_bytes = o_tx_remote ? 7'h00 : dlc_bytes;

  // Compare sent bit against bus; recessive is 1
  always_comb begin
    chk_res = cmh_pkg::CMH_TX_OK;
    if (i_chk_srr && hdr_q[`CMH_BIT_IDE] && !i_bus_bit) begin
      chk_res = cmh_pkg::CMH_TX_ARB_LOSS;
    end else if (i_chk_rtr) begin
      if (hdr_q[`CMH_BIT_RTR] && !i_bus_bit) begin
        chk_res = cmh_pkg::CMH_TX_ARB_LOSS;
      end else if (!hdr_q[`CMH_BIT_RTR] && i_bus_bit) begin
        chk_res = cmh_pkg::CMH_TX_BIT_ERR;
      end
    end
  end

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      arb_loss_q <= 1'b0;
      bit_err_q  <= 1'b0;
    end else begin
      arb_loss_q <= (chk_res == cmh_pkg::CMH_TX_ARB_LOSS);
      bit_err_q  <= (chk_res == cmh_pkg::CMH_TX_BIT_ERR);
    end
  end
  assign o_arb_loss  = arb_loss_q;
  assign o_bit_error = bit_err_q;

  // Mailbox code transitions
  AST_EMPTY_TO_FULL: assert property (
    @(posedge i_core_clk) disable iff (i_rst)
    i_rx_store && code == `CMH_CODE_RX_EMPTY && !i_tx_done |=>
    code == `CMH_CODE_RX_FULL) else $error("Empty store not full");
  AST_OVERRUN: assert property (
    @(posedge i_core_clk) disable iff (i_rst)
    i_rx_store && code == `CMH_CODE_RX_FULL && unread_q |=>
    code == `CMH_CODE_RX_OVERRUN) else $error("Overrun missed");
  AST_FULL_AGAIN: assert property (
    @(posedge i_core_clk) disable iff (i_rst)
    i_rx_store && code == `CMH_CODE_RX_OVERRUN && !unread_q |=>
    code == `CMH_CODE_RX_FULL) else $error("Serviced store not full");
  AST_TX_RETURN: assert property (
    @(posedge i_core_clk) disable iff (i_rst)
    i_tx_done && code == `CMH_CODE_TX_DATA |=>
    code == `CMH_CODE_TX_INACT) else $error("Tx code not inactive");
  AST_BUSY_HOLD: assert property (
    @(posedge i_core_clk) disable iff (i_rst)
    code[0] && !cpu_wr_acc && !i_tx_done |=>
    $stable(hdr_q[31:16])) else $error("Busy mailbox changed");
  AST_BUSY_NOMATCH: assert property (
    @(posedge i_core_clk) disable iff (i_rst)
    code[0] |->
    !o_rx_match_enable) else $error("Busy mailbox matches");
  AST_CPU_WRITE: assert property (
    @(posedge i_core_clk) disable iff (i_rst)
    cpu_wr_acc && !i_rx_store && !i_tx_done |=>
    {hdr_q[31:16], 16'h0000} == ($past(i_cpu_wdata) & WR_MASK)) else $error("Write lost");

  // Stored frame fields; flag layout of the engine port, unused bits masked
  AST_RX_FLAGS: assert property (
    @(posedge i_core_clk) disable iff (i_rst)
    i_rx_store && !code[0] |=> ({hdr_q[31:29], hdr_q[22:20], 2'h0, hdr_q[19:16]}
    == ($past(i_rx_flags) & 12'hFCF))) else $error("Received fields not stored");
  AST_RSV_ZERO: assert property (
    @(posedge i_core_clk) disable iff (i_rst)
    !hdr_q[`CMH_BIT_RSV_HI] &&
    !hdr_q[`CMH_BIT_RSV_LO]) else $error("Reserved bit set");

  // Timestamp capture and counter
  AST_TS_CAPTURE: assert property (
    @(posedge i_core_clk) disable iff (i_rst)
    i_id_start |=>
    hdr_q[15:0] == $past(ts_q)) else $error("Timestamp wrong");
  AST_TS_READONLY: assert property (
    @(posedge i_core_clk) disable iff (i_rst)
    !i_id_start |=>
    $stable(hdr_q[15:0])) else $error("Timestamp changed without capture");
  AST_TS_WRAP: assert property (
    @(posedge i_core_clk) disable iff (i_rst)
    ts_q == 16'hFFFF |=>
    ts_q == 16'h0000) else $error("Counter no wrap");
  AST_TS_COUNT: assert property (
    @(posedge i_core_clk) disable iff (i_rst)
    ts_q != 16'hFFFF |=>
    ts_q == $past(ts_q) + 16'h0001) else $error("Counter skipped");

  // Transmit-side views
  AST_ESI_ABSENT: assert property (
    @(posedge i_core_clk) disable iff (i_rst)
    !hdr_q[`CMH_BIT_FDF] |->
    !o_tx_esi_present) else $error("ESI in classical");
  AST_REMOTE_NODATA: assert property (
    @(posedge i_core_clk) disable iff (i_rst)
    o_tx_remote |->
    o_tx_payload_bytes == 7'h00) else $error("Remote has data");
  AST_PAYLOAD_SMALL: assert property (
    @(posedge i_core_clk) disable iff (i_rst)
    !o_tx_remote && hdr_q[`CMH_DLC_HI:`CMH_DLC_LO] <= 4'h8 |->
    o_tx_payload_bytes == {3'h0, hdr_q[`CMH_DLC_HI:`CMH_DLC_LO]}) else $error("Short length");
  AST_PAYLOAD_MAX: assert property (
    @(posedge i_core_clk) disable iff (i_rst)
    !o_tx_remote && hdr_q[`CMH_DLC_HI:`CMH_DLC_LO] == 4'hF |->
    o_tx_payload_bytes == 7'h40) else $error("Longest length wrong");

  // Sent bit against bus bit
  AST_RTR_BITERR: assert property (
    @(posedge i_core_clk) disable iff (i_rst)
    i_chk_rtr && !i_chk_srr && !hdr_q[`CMH_BIT_RTR] && i_bus_bit |=>
    o_bit_error) else $error("RTR bit error missed");
  AST_RTR_ARBLOSS: assert property (
    @(posedge i_core_clk) disable iff (i_rst)
    i_chk_rtr && !i_chk_srr && hdr_q[`CMH_BIT_RTR] && !i_bus_bit |=>
    o_arb_loss) else $error("RTR arbitration loss missed");
  AST_RTR_MATCH: assert property (
    @(posedge i_core_clk) disable iff (i_rst)
    i_chk_rtr && !i_chk_srr && (hdr_q[`CMH_BIT_RTR] == i_bus_bit) |=>
    !o_arb_loss && !o_bit_error) else $error("RTR match flagged");
  AST_SRR_ARBLOSS: assert property (
    @(posedge i_core_clk) disable iff (i_rst)
    i_chk_srr && hdr_q[`CMH_BIT_IDE] && !i_bus_bit |=>
    o_arb_loss) else $error("SRR arbitration loss missed");
  AST_SRR_STD: assert property (
    @(posedge i_core_clk) disable iff (i_rst)
    i_chk_srr && !i_chk_rtr && !hdr_q[`CMH_BIT_IDE] |=>
    !o_arb_loss && !o_bit_error) else $error("SRR checked in standard frame");
  AST_CHECK_IDLE: assert property (
    @(posedge i_core_clk) disable iff (i_rst)
    !i_chk_srr && !i_chk_rtr |=>
    !o_arb_loss && !o_bit_error) else $error("Check result without check");

  COV_STORE_FULL: cover property (@(posedge i_core_clk) disable iff (i_rst)
    i_rx_store && code == `CMH_CODE_RX_EMPTY);
  COV_OVERRUN: cover property (@(posedge i_core_clk) disable iff (i_rst)
    i_rx_store && code == `CMH_CODE_RX_FULL && unread_q);
  COV_TX_DONE: cover property (@(posedge i_core_clk) disable iff (i_rst)
    i_tx_done && code == `CMH_CODE_TX_DATA);
  COV_ARB_LOSS: cover property (@(posedge i_core_clk) disable iff (i_rst)
    o_arb_loss);
  COV_BIT_ERR: cover property (@(posedge i_core_clk) disable iff (i_rst)
    o_bit_error);
endmodule // cmh_header

// file: cmh_bus_node.sv
// Far-side CAN node model: forces one bus bit or leaves the bus alone
// Assumes the bench asks for a bit only in a check cycle
`timescale 1ns/1ps
module cmh_bus_node (
  input  wire logic i_drive,
  input  wire logic i_level,
  output logic      o_bus_bit
);
  // Released bus settles recessive, the level the line is pulled to
  assign o_bus_bit = i_drive ? i_level : 1'b1;
endmodule  // cmh_bus_node

// file: testbench.sv
// Self-checking bench for the mailbox header word block
// Assumes the design files and cmh_bus_node are compiled before it
`timescale 1ns/1ps
`include "cmh_defs.svh"
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin err_count++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e); end end
module testbench;
  logic        i_core_clk = 1'b0, i_rst = 1'b1, sel = 1'b0, wr = 1'b0, rd_ready = 1'b0;
  logic        serviced = 1'b0, rx_store = 1'b0, tx_done = 1'b0, id_start = 1'b0;
  logic        passive = 1'b0, chk_srr = 1'b0, chk_rtr = 1'b0, drive = 1'b0, level = 1'b1;
  logic [11:0] addr = 12'h000, rx_flags = 12'h000;
  logic [31:0] wdata = 32'h0000_0000, rdata;
  logic [15:0] ts_cap = 16'h0000, tstamp;
  logic        rd_valid, cpu_ready, bus_bit, esi_bit, esi_pres, tx_remote, match_en;
  logic        acc_remote, arb_loss, bit_err;
  logic [6:0]  pay_bytes;
  int          err_count = 0, samples_checked = 0;
  // Length code beside its payload size
  logic [10:0] rows [16] = '{{4'h0, 7'h00}, {4'h1, 7'h01}, {4'h2, 7'h02}, {4'h3, 7'h03},
    {4'h4, 7'h04}, {4'h5, 7'h05}, {4'h6, 7'h06}, {4'h7, 7'h07}, {4'h8, 7'h08},
    {4'h9, 7'h0C}, {4'hA, 7'h10}, {4'hB, 7'h14}, {4'hC, 7'h18}, {4'hD, 7'h20},
    {4'hE, 7'h30}, {4'hF, 7'h40}};

  always #5 i_core_clk = ~i_core_clk;

  cmh_bus_node NODE (.i_drive(drive), .i_level(level), .o_bus_bit(bus_bit));
  cmh_header DUT (
    .i_core_clk(i_core_clk), .i_rst(i_rst), .i_cpu_sel(sel), .i_cpu_wr(wr),
    .i_cpu_addr(addr), .i_cpu_wdata(wdata), .i_cpu_rd_ready(rd_ready),
    .o_cpu_rd_valid(rd_valid), .o_cpu_rdata(rdata), .o_cpu_ready(cpu_ready),
    .i_cpu_serviced(serviced), .i_rx_store(rx_store), .i_rx_flags(rx_flags),
    .i_tx_done(tx_done), .i_id_start(id_start), .i_error_passive(passive),
    .i_chk_srr(chk_srr), .i_chk_rtr(chk_rtr), .i_bus_bit(bus_bit),
    .o_tx_esi_bit(esi_bit), .o_tx_esi_present(esi_pres), .o_tx_remote(tx_remote),
    .o_tx_payload_bytes(pay_bytes), .o_rx_match_enable(match_en),
    .o_rx_accept_remote(acc_remote), .o_arb_loss(arb_loss), .o_bit_error(bit_err),
    .o_timestamp(tstamp));

  task automatic cyc(int n);
    repeat (n) @(negedge i_core_clk);
  endtask
  task automatic cpu_acc(logic w, logic [11:0] a, logic [31:0] d);
    sel = 1'b1;
    wr = w;
    addr = a;
    wdata = d;
    cyc(1);
  endtask
  task automatic wr_word(logic [31:0] d);
    cpu_acc(1'b1, `CMH_HDR_OFFSET, d);
    sel = 1'b0;
    cyc(1);
  endtask
  task automatic rd_chk(logic [31:0] e);
    cpu_acc(1'b0, `CMH_HDR_OFFSET, 32'h0000_0000);
    sel = 1'b0;
    `CHK(rd_valid, 1'b1)
    `CHK(rdata, e)
    rd_ready = 1'b1;
    cyc(1);
    rd_ready = 1'b0;
  endtask
  task automatic pulse(ref logic s);
    s = 1'b1;
    cyc(1);
    s = 1'b0;
    cyc(1);
  endtask
  task automatic rx_pulse(logic [11:0] f);
    rx_flags = f;
    pulse(rx_store);
  endtask
  task automatic bit_chk(logic s, logic lvl, logic [1:0] e);
    chk_srr = s;
    chk_rtr = !s;
    drive = 1'b1;
    level = lvl;
    cyc(1);
    chk_srr = 1'b0;
    chk_rtr = 1'b0;
    drive = 1'b0;
    `CHK({arb_loss, bit_err}, e)
    cyc(1);
  endtask
  task automatic done(string s);
    $display("test %s done", s);
  endtask
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  // Whole run is about 65.5k cycles, mostly the counter wrap
  initial begin
    #1_000_000;
    err_count++;
    finish_test();
  end

  initial begin
    logic [15:0] t;
    repeat (12) @(posedge i_core_clk);
    @(negedge i_core_clk);
    i_rst = 1'b0;
    rd_chk(`CMH_HDR_RESET);
    t = tstamp;
    cyc(1);
    `CHK(tstamp, t + 16'h0001)
    done("reset");
    for (int i = 0; i < 16; i++) begin
      wr_word({8'h08, 4'h0, rows[i][10:7], 16'h0000});
      `CHK(pay_bytes, rows[i][6:0])
    end
    done("length table");
    wr_word(32'hC70F_FFFF);
    rd_chk({16'hC70F, ts_cap});
    `CHK(esi_pres, 1'b1)
    `CHK(match_en, 1'b0)
    passive = 1'b1;
    cyc(1);
    `CHK(esi_bit, 1'b1)
    passive = 1'b0;
    cyc(1);
    `CHK(esi_bit, 1'b0)
    wr_word(32'h0808_0000);
    `CHK(esi_pres, 1'b0)
    bit_chk(1'b0, 1'b1, 2'h1);
    bit_chk(1'b0, 1'b0, 2'h0);
    bit_chk(1'b1, 1'b0, 2'h0);
    wr_word(32'h0818_0000);
    `CHK({tx_remote, acc_remote, pay_bytes}, 9'h180)
    bit_chk(1'b0, 1'b0, 2'h2);
    bit_chk(1'b0, 1'b1, 2'h0);
    wr_word(32'h0868_0000);
    bit_chk(1'b1, 1'b0, 2'h2);
    done("transmit flags");
    id_start = 1'b1;
    ts_cap = tstamp;
    cyc(1);
    id_start = 1'b0;
    cyc(1);
    rd_chk({16'h0868, ts_cap});
    wr_word(32'h0400_0000);
    `CHK(match_en, 1'b1)
    rx_pulse(12'hF8D);
    rd_chk({16'hE26D, ts_cap});
    rx_pulse(12'hF8D);
    rd_chk({16'hE66D, ts_cap});
    pulse(serviced);
    rx_pulse(12'h00F);
    rd_chk({16'h020F, ts_cap});
    wr_word(32'h0500_0000);
    rx_pulse(12'h008);
    rd_chk({16'h0500, ts_cap});
    wr_word(32'h0C08_0000);
    pulse(tx_done);
    rd_chk({16'h0808, ts_cap});
    done("mailbox codes");
    cpu_acc(1'b0, 12'h084, 32'h0000_0000);
    sel = 1'b0;
    cyc(1);
    `CHK(rd_valid, 1'b0)
    // Reader stalls while eight reads pile up
    for (int i = 0; i < 8; i++) cpu_acc(1'b0, `CMH_HDR_OFFSET, 32'h0000_0000);
    `CHK(cpu_ready, 1'b0)
    sel = 1'b0;
    rd_ready = 1'b1;
    for (int i = 0; i < 8; i++) begin
      `CHK(rdata, {16'h0808, ts_cap})
      cyc(1);
    end
    rd_ready = 1'b0;
    `CHK(rd_valid, 1'b0)
    done("read buffer");
    for (int k = 0; k < 70000 && tstamp !== 16'hFFFF; k++) cyc(1);
    cyc(1);
    `CHK(tstamp, 16'h0000)
    done("counter wrap");
    finish_test();
  end
endmodule  // testbench
